/* inc/cbc_map.svh */
/*
 * Offsets-free constant map for the bus control block: cycle classes,
 * address layout and slow clock phase counts.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef CBC_MAP_SVH
`define CBC_MAP_SVH

// ----------------------------------------------------------------
// slow peripheral clock phases (input clock periods)
// ----------------------------------------------------------------
`define CBC_SLOW_LOW_CYC 6
`define CBC_SLOW_HIGH_CYC 4
`define CBC_SLOW_PERIOD (`CBC_SLOW_LOW_CYC + `CBC_SLOW_HIGH_CYC)

// ----------------------------------------------------------------
// cycle class codes, msb first
// ----------------------------------------------------------------
`define CBC_CC_USER_DATA 3'h1
`define CBC_CC_USER_PROG 3'h2
`define CBC_CC_SUP_DATA 3'h5
`define CBC_CC_SUP_PROG 3'h6
`define CBC_CC_INT_ACK 3'h7

// ----------------------------------------------------------------
// address layout
// ----------------------------------------------------------------
`define CBC_ADDR_W 23
`define CBC_LONG_STEP 23'h00_0001
`define CBC_IACK_HIGH 20'hF_FFFF

`endif

/* inc/cbc_pkg.sv */
/*
 * Types for the bus control block.
 * Assumes cbc_map.svh is on the include path.
 */
`include "cbc_map.svh"

package cbc_pkg;

    typedef enum logic [2:0] {
        CBC_SZ_BYTE = 3'b001,
        CBC_SZ_WORD = 3'b010,
        CBC_SZ_LONG = 3'b100
    } cbc_size_t;

    // one request from the execution core
    typedef struct packed {
        logic [23:0] byte_addr;
        logic rd;
        cbc_size_t size;
        logic [2:0] cycle_class;
        logic [2:0] irq_level;
        logic [31:0] wdata;
    } cbc_req_t;

    // bus-side pin group, drive values only; output enables are separate ports
    typedef struct packed {
        logic [22:0] addr;
        logic [15:0] data;
        logic as_n;
        logic rd_wr_n;
        logic ubs_n;
        logic lbs_n;
        logic vma_n;
        logic [2:0] cc;
    } cbc_pins_t;

endpackage : cbc_pkg

/* design/cbc_slow_clock.sv */
/*
 * Free-running ring counter producing the slow peripheral clock.
 * Assumes one continuously running input clock.
 */
`timescale 1ns/10ps
`include "cbc_map.svh"

module cbc_slow_clock #(
    parameter int LOW_CYC = `CBC_SLOW_LOW_CYC,
    parameter int HIGH_CYC = `CBC_SLOW_HIGH_CYC
) (
    // clock
    input wire logic clk_in,
    // slow clock and its edges
    output logic slow_clk_out,
    output logic slow_fall_out,
    output logic slow_rise_out
);
    localparam int PERIOD = LOW_CYC + HIGH_CYC;

    // ring is 16 flops wide, so longer periods cannot be served
    if (LOW_CYC < 1 || HIGH_CYC < 1 || PERIOD > 16) begin : g_bad_phase
        $error("slow clock phases out of range");
    end

    // ----------------------------------------------------------------
    // ring counter
    // ----------------------------------------------------------------
    // no reset: starting phase is arbitrary, runs regardless of bus state
    logic [15:0] ring_q = 16'h0001;

    always_ff @(posedge clk_in) begin
        ring_q <= {ring_q[14:0], ring_q[PERIOD-1]} & 16'((1 << PERIOD) - 1);
    end

    logic [15:0] high_mask;
    assign high_mask = 16'(((1 << HIGH_CYC) - 1) << LOW_CYC);

    assign slow_clk_out = |(ring_q & high_mask);
    assign slow_rise_out = ring_q[LOW_CYC-1];
    assign slow_fall_out = ring_q[PERIOD-1];

    property p_slow_low;
        @(posedge clk_in) $fell(slow_clk_out) |-> !slow_clk_out [*6];
    endproperty
    a_slow_low: assert property (p_slow_low) else $error("slow clock low phase not six cycles");
endmodule : cbc_slow_clock

/* design/cbc_bus_ctrl.sv */
/*
 * Bus control side of the processor: stop line, strobes, cycle class,
 * slow peripheral handshake, byte placement and bus release.
 * Assumes pins arrive unsynchronised and the core holds a request until done.
 */
// Functional notes
// - external stop: finish cycle, then idle
// - stopped: controls inactive, three-state lines float
// - drive stop line when processor halts
// - slow clock: six low, four high
// - slow clock free-running, arbitrary start phase
// - peripheral select syncs transfer to slow clock
// - peripheral select in acknowledge means autovector
// - sync address valid only on peripheral select
// - cycle class code encodings
// - cycle class stable while address strobe asserted
// - on takeover float controls; stopped floats address/data
// - high byte at even address
// - multi-byte accesses word aligned only
// - long word second half at n plus two
// - byte access strobe chosen by byte select bit
// - acknowledge address: level low, rest high
`timescale 1ns/10ps
`include "cbc_map.svh"

module cbc_bus_ctrl (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // core request
    input wire logic req_valid_in,
    input wire cbc_pkg::cbc_req_t req_in,
    input wire logic core_halted_in,
    output logic req_ready_out,
    output logic req_done_out,
    output logic req_fault_out,
    output logic req_autovec_out,
    output logic [31:0] rdata_out,
    // bus pins, active low where named _n
    output cbc_pkg::cbc_pins_t pin_drv_out,
    output logic addr_oe_out,
    output logic data_oe_out,
    output logic ctrl_oe_out,
    input wire logic [15:0] data_in,
    input wire logic transfer_ack_n_in,
    input wire logic bus_fault_n_in,
    input wire logic sync_peripheral_select_n_in,
    input wire logic take_over_confirm_n_in,
    input wire logic [2:0] irq_level_n_in,
    // stop line, open drain
    input wire logic stop_n_in,
    output logic stop_n_out,
    output logic stop_oe_out,
    // slow peripheral clock
    output logic slow_clk_out
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_WAIT = 5'b00100,
        ST_SYNC = 5'b01000,
        ST_END = 5'b10000
    } cbc_state_t;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] s1_q, s2_q;
    logic [15:0] d1_q, d2_q;
    logic [2:0] i1_q, i2_q;
    always_ff @(posedge clk_in) begin
        s1_q <= {transfer_ack_n_in, bus_fault_n_in, sync_peripheral_select_n_in, take_over_confirm_n_in, stop_n_in};
        s2_q <= s1_q;
        d1_q <= data_in;
        d2_q <= d1_q;
        i1_q <= irq_level_n_in;
        i2_q <= i1_q;
    end
    logic ack, fault, psel, taken, ext_stop;
    assign ack = !s2_q[4];
    assign fault = !s2_q[3];
    assign psel = !s2_q[2];
    assign taken = !s2_q[1];
    assign ext_stop = !s2_q[0] && !core_halted_in;
    // answers must be seen released before the next cycle, else a stale ack ends it early
    logic released;
    assign released = !ack && !fault && !psel;

    // ----------------------------------------------------------------
    // slow clock
    // ----------------------------------------------------------------
    logic slow_fall, slow_rise;
    cbc_slow_clock u_slow (
        .clk_in(clk_in),
        .slow_clk_out(slow_clk_out),
        .slow_fall_out(slow_fall),
        .slow_rise_out(slow_rise)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [22:0] word_addr(input logic [23:0] a, input logic second, input logic [2:0] lvl,
                                              input logic iack);
        if (iack) begin
            word_addr = {`CBC_IACK_HIGH, lvl};
        end else begin
            word_addr = a[23:1] + (second ? `CBC_LONG_STEP : 23'h00_0000);
        end
    endfunction : word_addr

    function automatic logic legal_class(input logic [2:0] c);
        legal_class = (c == `CBC_CC_USER_DATA) || (c == `CBC_CC_USER_PROG) || (c == `CBC_CC_SUP_DATA) ||
                      (c == `CBC_CC_SUP_PROG) || (c == `CBC_CC_INT_ACK);
    endfunction : legal_class

    // ----------------------------------------------------------------
    // cycle state
    // ----------------------------------------------------------------
    cbc_state_t state_q;
    cbc_pkg::cbc_req_t req_q;
    logic second_q, sync_q, stopped_q;
    logic iack;
    logic bad_req;
    assign iack = req_q.cycle_class == `CBC_CC_INT_ACK;
    assign bad_req = !legal_class(req_in.cycle_class) ||
                     (req_in.size != cbc_pkg::CBC_SZ_BYTE && req_in.byte_addr[0]);

    // new cycles start only when neither stopped nor released
    assign req_ready_out = (state_q == ST_IDLE) && !ext_stop && !taken && !core_halted_in;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state_q <= ST_IDLE;
            second_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    second_q <= 1'b0;
                    sync_q <= 1'b0;
                    if (req_valid_in && req_ready_out && !bad_req) begin
                        state_q <= ST_ADDR;
                    end
                end
                ST_ADDR: state_q <= ST_WAIT;
                ST_WAIT: begin
                    if (fault) begin
                        state_q <= ST_END;
                    end else if (psel) begin
                        state_q <= ST_SYNC;
                    end else if (ack) begin
                        state_q <= ST_END;
                    end
                end
                ST_SYNC: begin
                    if (slow_rise) begin
                        sync_q <= 1'b1;
                    end
                    if (sync_q && slow_fall) begin
                        sync_q <= 1'b0;
                        state_q <= ST_END;
                    end
                end
                ST_END: begin
                    if (released) begin
                        if (req_q.size == cbc_pkg::CBC_SZ_LONG && !second_q && !req_fault_out) begin
                            second_q <= 1'b1;
                            state_q <= ST_ADDR;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // request held for the whole cycle so class cannot move under the strobe
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            req_q <= '0;
        end else if (state_q == ST_IDLE && req_valid_in && req_ready_out) begin
            req_q <= req_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            stopped_q <= 1'b0;
        end else begin
            stopped_q <= ext_stop && (state_q == ST_IDLE);
        end
    end

    // ----------------------------------------------------------------
    // read data and completion
    // ----------------------------------------------------------------
    logic latch;
    assign latch = (state_q == ST_WAIT && ack && !psel && !fault) || (state_q == ST_SYNC && sync_q && slow_fall);
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rdata_out <= 32'h0000_0000;
            req_done_out <= 1'b0;
            req_fault_out <= 1'b0;
            req_autovec_out <= 1'b0;
        end else begin
            req_done_out <= 1'b0;
            if (state_q == ST_IDLE && req_valid_in && req_ready_out && bad_req) begin
                req_done_out <= 1'b1;
                req_fault_out <= 1'b1;
            end
            if (state_q == ST_WAIT && fault) begin
                req_fault_out <= 1'b1;
            end
            if (state_q == ST_ADDR && !second_q) begin
                req_fault_out <= 1'b0;
                req_autovec_out <= 1'b0;
            end
            if (state_q == ST_WAIT && psel && iack) begin
                req_autovec_out <= 1'b1;
            end
            if (latch && req_q.rd) begin
                if (req_q.size == cbc_pkg::CBC_SZ_BYTE) begin
                    rdata_out <= {24'h00_0000, req_q.byte_addr[0] ? d2_q[7:0] : d2_q[15:8]};
                end else if (second_q || req_q.size == cbc_pkg::CBC_SZ_WORD) begin
                    rdata_out[15:0] <= d2_q;
                end else begin
                    rdata_out[31:16] <= d2_q;
                end
            end
            if (state_q == ST_END && released &&
                !(req_q.size == cbc_pkg::CBC_SZ_LONG && !second_q && !req_fault_out)) begin
                req_done_out <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    logic busy;
    logic [15:0] wword;
    assign busy = (state_q == ST_WAIT) || (state_q == ST_SYNC) || (state_q == ST_ADDR);
    assign wword = (req_q.size == cbc_pkg::CBC_SZ_BYTE) ? {2{req_q.wdata[7:0]}} :
                   (req_q.size == cbc_pkg::CBC_SZ_LONG && !second_q) ? req_q.wdata[31:16] : req_q.wdata[15:0];

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pin_drv_out <= '1;
        end else begin
            pin_drv_out.addr <= word_addr(req_q.byte_addr, second_q, ~i2_q, iack);
            pin_drv_out.data <= wword;
            pin_drv_out.rd_wr_n <= !busy || req_q.rd;
            pin_drv_out.as_n <= !busy;
            // byte strobe from the byte select bit
            pin_drv_out.ubs_n <= !(busy && state_q != ST_ADDR &&
                                   (req_q.size != cbc_pkg::CBC_SZ_BYTE || !req_q.byte_addr[0]));
            pin_drv_out.lbs_n <= !(busy && state_q != ST_ADDR &&
                                   (req_q.size != cbc_pkg::CBC_SZ_BYTE || req_q.byte_addr[0]));
            pin_drv_out.vma_n <= !(state_q == ST_SYNC && sync_q && !(slow_fall));
            pin_drv_out.cc <= req_q.cycle_class;
        end
    end

    // stop floats address/data, takeover floats all controls
    assign addr_oe_out = !stopped_q && !taken;
    // follows the registered write level so data stands as long as the strobes
    assign data_oe_out = !stopped_q && !taken && !pin_drv_out.rd_wr_n;
    assign ctrl_oe_out = !taken;

    assign stop_n_out = 1'b0;
    assign stop_oe_out = core_halted_in;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_class_stable;
        @(posedge clk_in) disable iff (!rst_b_in)
        (!pin_drv_out.as_n && !$past(pin_drv_out.as_n)) |-> $stable(pin_drv_out.cc);
    endproperty
    a_class_stable: assert property (p_class_stable) else $error("cycle class moved under strobe");

    property p_vma_needs_psel;
        @(posedge clk_in) disable iff (!rst_b_in)
        !pin_drv_out.vma_n |-> $past(state_q == ST_SYNC);
    endproperty
    a_vma_needs_psel: assert property (p_vma_needs_psel) else $error("sync valid without select");

    property p_stop_drive;
        @(posedge clk_in) disable iff (!rst_b_in)
        core_halted_in |-> stop_oe_out && !stop_n_out;
    endproperty
    a_stop_drive: assert property (p_stop_drive) else $error("stop line not driven on halt");

    property p_stopped_idle;
        @(posedge clk_in) disable iff (!rst_b_in)
        stopped_q |-> !addr_oe_out && !data_oe_out && pin_drv_out.as_n;
    endproperty
    a_stopped_idle: assert property (p_stopped_idle) else $error("stopped but bus active");

    property p_no_start_stopped;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ext_stop && state_q == ST_IDLE) |=> state_q == ST_IDLE;
    endproperty
    a_no_start_stopped: assert property (p_no_start_stopped) else $error("cycle began while stopped");

    property p_takeover_float;
        @(posedge clk_in) disable iff (!rst_b_in)
        taken |-> !ctrl_oe_out && !addr_oe_out;
    endproperty
    a_takeover_float: assert property (p_takeover_float) else $error("takeover but outputs driven");

    property p_legal_class;
        @(posedge clk_in) disable iff (!rst_b_in)
        !pin_drv_out.as_n |-> legal_class(pin_drv_out.cc);
    endproperty
    a_legal_class: assert property (p_legal_class) else $error("reserved cycle class driven");

    property p_byte_strobe;
        @(posedge clk_in) disable iff (!rst_b_in)
        (!pin_drv_out.ubs_n && req_q.size == cbc_pkg::CBC_SZ_BYTE) |-> pin_drv_out.lbs_n;
    endproperty
    a_byte_strobe: assert property (p_byte_strobe) else $error("two strobes on byte access");
endmodule : cbc_bus_ctrl

/* tb/cbc_mem_model.sv */
/*
 * Far-side memory and peripheral model for the bus control block.
 * Assumes the bench resolves the data wire and feeds it back in.
 */
`timescale 1ns/10ps

module cbc_mem_model (
    // clock
    input wire logic clk_in,
    // bus seen from the block
    input wire cbc_pkg::cbc_pins_t pin_in,
    input wire logic ctrl_oe_in,
    input wire logic [15:0] data_wire_in,
    // answers, active low where named _n
    output logic [15:0] data_out,
    output logic transfer_ack_n_out,
    output logic bus_fault_n_out,
    output logic sync_peripheral_select_n_out
);
    // ----------------------------------------------------------------
    // memory and answer timing
    // ----------------------------------------------------------------
    logic [15:0] mem_q [0:255];
    int wait_q;
    logic act;

    assign act = ctrl_oe_in && !pin_in.as_n;

    initial begin
        for (int k = 0; k < 256; k++) begin
            mem_q[k] = {k[7:0], ~k[7:0]};
        end
        wait_q = 0;
        data_out = 16'h0000;
        transfer_ack_n_out = 1'b1;
        bus_fault_n_out = 1'b1;
        sync_peripheral_select_n_out = 1'b1;
    end

    always @(posedge clk_in) begin
        if (!act) begin
            // random wait gives both prompt and slow answers
            wait_q <= $urandom_range(3);
            transfer_ack_n_out <= 1'b1;
            bus_fault_n_out <= 1'b1;
            sync_peripheral_select_n_out <= 1'b1;
        end else if (pin_in.cc == 3'h7 || pin_in.addr[21]) begin
            sync_peripheral_select_n_out <= 1'b0;
        end else if (wait_q > 0) begin
            wait_q <= wait_q - 1;
        end else if (pin_in.addr[20]) begin
            bus_fault_n_out <= 1'b0;
        end else if (!pin_in.ubs_n || !pin_in.lbs_n) begin
            transfer_ack_n_out <= 1'b0;
        end
    end

    always @(posedge clk_in) begin
        if (act && !pin_in.rd_wr_n && !pin_in.ubs_n) begin
            mem_q[pin_in.addr[7:0]][15:8] <= data_wire_in[15:8];
        end
        if (act && !pin_in.rd_wr_n && !pin_in.lbs_n) begin
            mem_q[pin_in.addr[7:0]][7:0] <= data_wire_in[7:0];
        end
        // a released bus must not show its last value
        data_out <= (act && pin_in.rd_wr_n) ? mem_q[pin_in.addr[7:0]] : ~data_out;
    end
endmodule : cbc_mem_model

/* tb/tb_top.sv */
/*
 * Self-checking bench for the bus control block with a byte-level reference.
 * Assumes the far-side model in cbc_mem_model.sv.
 */
`timescale 1ns/10ps

module tb_top;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk_in, rst_b_in, req_valid, halted, req_ready, req_done, req_fault, req_av;
    cbc_pkg::cbc_req_t req_s;
    logic [31:0] rdata;
    cbc_pkg::cbc_pins_t pins;
    logic aoe, doe, coe, ack_n, flt_n, sel_n, conf_n, ext_stop_n, stop_n, stop_oe, slow;
    logic [2:0] irq_n;
    logic [15:0] mdl_data, data_wire;
    logic [7:0] rb [0:511];
    logic [22:0] addr_q [$];
    logic seen_u, seen_l, seen_v, as_prev, r_av;
    logic [2:0] cc_prev;
    int error_cnt, check_count;
    cbc_pkg::cbc_size_t szs [3] = '{cbc_pkg::CBC_SZ_BYTE, cbc_pkg::CBC_SZ_WORD, cbc_pkg::CBC_SZ_LONG};
    logic [2:0] ccs [4] = '{3'h1, 3'h2, 3'h5, 3'h6};

    assign data_wire = doe ? pins.data : mdl_data;

    cbc_bus_ctrl i_dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid), .req_in(req_s),
        .core_halted_in(halted), .req_ready_out(req_ready), .req_done_out(req_done),
        .req_fault_out(req_fault), .req_autovec_out(req_av), .rdata_out(rdata),
        .pin_drv_out(pins), .addr_oe_out(aoe), .data_oe_out(doe), .ctrl_oe_out(coe),
        .data_in(data_wire), .transfer_ack_n_in(ack_n), .bus_fault_n_in(flt_n),
        .sync_peripheral_select_n_in(sel_n), .take_over_confirm_n_in(conf_n),
        .irq_level_n_in(irq_n), .stop_n_in(ext_stop_n & ~(stop_oe & ~stop_n)),
        .stop_n_out(stop_n), .stop_oe_out(stop_oe), .slow_clk_out(slow));

    cbc_mem_model i_mem (
        .clk_in(clk_in), .pin_in(pins), .ctrl_oe_in(coe), .data_wire_in(data_wire),
        .data_out(mdl_data), .transfer_ack_n_out(ack_n), .bus_fault_n_out(flt_n),
        .sync_peripheral_select_n_out(sel_n));

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------------------------------
    // bus monitor
    // ----------------------------------------------------------------
    always @(posedge clk_in) begin
        if (coe && !pins.as_n) begin
            if (as_prev) addr_q.push_back(pins.addr);
            if (!as_prev) chk(pins.cc, cc_prev);
            if (!pins.ubs_n) seen_u = 1'b1;
            if (!pins.lbs_n) seen_l = 1'b1;
            if (!pins.vma_n) seen_v = 1'b1;
        end
        as_prev = !(coe && !pins.as_n);
        cc_prev = pins.cc;
    end

    task automatic bus_op(input logic [23:0] a, input logic rd, input cbc_pkg::cbc_size_t sz,
                          input logic [2:0] cc, input logic [31:0] wd, input logic bad);
        int n;
        int nb;
        logic [31:0] ex;
        nb = (sz == cbc_pkg::CBC_SZ_BYTE) ? 1 : (sz == cbc_pkg::CBC_SZ_WORD) ? 2 : 4;
        ex = 32'h0000_0000;
        n = 0;
        @(negedge clk_in);
        addr_q.delete();
        seen_u = 1'b0;
        seen_l = 1'b0;
        seen_v = 1'b0;
        req_s = '{a, rd, sz, cc, 3'h0, wd};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 400) begin @(negedge clk_in); n++; end
        @(negedge clk_in);
        req_valid = 1'b0;
        while (req_done !== 1'b1 && n < 800) begin @(negedge clk_in); n++; end
        if (n >= 800) error_cnt++;
        r_av = req_av;
        chk(req_fault, bad);
        if (!bad && cc != 3'h7) begin
            for (int k = 0; k < nb; k++) begin
                ex = {ex[23:0], rb[9'(a + k)]};
                if (!rd) rb[9'(a + k)] = wd[8 * (nb - 1 - k) +: 8];
            end
            if (rd) chk(rdata & ((nb == 4) ? 32'hFFFF_FFFF : (32'h1 << (8 * nb)) - 1), ex);
            chk(addr_q.size(), (nb + 1) / 2);
            for (int k = 0; k < addr_q.size(); k++) chk(addr_q[k], a[23:1] + k);
            chk(seen_v, a[22]);
            if (nb == 1) chk({seen_u, seen_l}, {~a[0], a[0]});
            else chk({seen_u, seen_l}, 2'b11);
        end
    endtask : bus_op

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        int hi;
        int lo;
        logic [23:0] a;
        cbc_pkg::cbc_size_t sz;
        error_cnt = 0;
        check_count = 0;
        rst_b_in = 1'b0;
        req_valid = 1'b0;
        req_s = '0;
        halted = 1'b0;
        conf_n = 1'b1;
        irq_n = 3'h7;
        ext_stop_n = 1'b1;
        as_prev = 1'b1;
        cc_prev = 3'h0;
        for (int k = 0; k < 256; k++) begin
            rb[2 * k] = k[7:0];
            rb[2 * k + 1] = ~k[7:0];
        end
        void'($urandom(32'h961f_f6a6));
        repeat (3) @(negedge clk_in);
        rst_b_in = 1'b1;
        for (int i = 0; i < 48; i++) begin
            sz = szs[$urandom_range(2)];
            a = {15'h0000, 8'($urandom), (sz == cbc_pkg::CBC_SZ_BYTE) ? 1'($urandom) : 1'b0};
            if (i % 4 == 3) a[22] = 1'b1;
            bus_op(a, 1'($urandom), sz, ccs[$urandom_range(3)], $urandom, 1'b0);
        end
        foreach (szs[k]) begin
            if (k > 0) bus_op(24'h00_0021, 1'b1, szs[k], 3'h1, 32'h0, 1'b1);
            if (k > 0) chk(addr_q.size(), 0);
        end
        // reserved classes 0, 3 and 4
        foreach (ccs[k]) begin
            if (k < 3) bus_op(24'h00_0010, 1'b1, cbc_pkg::CBC_SZ_WORD, 3'((k == 0) ? 0 : k + 2), 32'h0, 1'b1);
            if (k < 3) chk(addr_q.size(), 0);
        end
        bus_op(24'h20_0040, 1'b1, cbc_pkg::CBC_SZ_WORD, 3'h5, 32'h0, 1'b1);
        for (int lvl = 1; lvl < 8; lvl++) begin
            irq_n = ~3'(lvl);
            repeat (4) @(negedge clk_in);
            bus_op(24'h00_0010, 1'b1, cbc_pkg::CBC_SZ_WORD, 3'h7, 32'h0, 1'b0);
            chk(r_av, 1'b1);
            chk(addr_q[0], {20'hF_FFFF, 3'(lvl)});
        end
        fork
            bus_op(24'h00_0080, 1'b0, cbc_pkg::CBC_SZ_WORD, 3'h1, $urandom, 1'b0);
            begin repeat (3) @(negedge clk_in); ext_stop_n = 1'b0; end
        join
        repeat (4) @(negedge clk_in);
        chk({req_ready, aoe, doe, pins.as_n, pins.ubs_n, pins.vma_n}, 6'b000111);
        ext_stop_n = 1'b1;
        repeat (6) @(negedge clk_in);
        bus_op(24'h00_0080, 1'b1, cbc_pkg::CBC_SZ_WORD, 3'h1, 32'h0, 1'b0);
        conf_n = 1'b0;
        repeat (4) @(negedge clk_in);
        chk({req_ready, aoe, doe, coe}, 4'b0000);
        while (slow !== 1'b0 && hi < 40) begin @(negedge clk_in); hi++; end
        while (slow !== 1'b1 && lo < 40) begin @(negedge clk_in); lo++; end
        repeat (3) begin
            hi = 0;
            lo = 0;
            while (slow === 1'b1 && hi < 20) begin @(negedge clk_in); hi++; end
            while (slow === 1'b0 && lo < 20) begin @(negedge clk_in); lo++; end
            chk(hi, 4);
            chk(lo, 6);
        end
        conf_n = 1'b1;
        halted = 1'b1;
        repeat (4) @(negedge clk_in);
        chk({stop_oe, stop_n, req_ready}, 3'b100);
        halted = 1'b0;
        repeat (6) @(negedge clk_in);
        bus_op(24'h00_0044, 1'b1, cbc_pkg::CBC_SZ_LONG, 3'h6, 32'h0, 1'b0);
        wrap_up();
    end

    initial begin
        #200_000;
        error_cnt++;
        wrap_up();
    end
endmodule : tb_top
